// ===== common/mie_regs.svh
// register map, field positions, reset values and cycle counts of the execute unit
// assumes a byte-addressed Avalon-MM slave with 32-bit data
`ifndef MIE_REGS_SVH
`define MIE_REGS_SVH
`define MIE_OFF_OPER 8'h00
`define MIE_OFF_ADDR 8'h04
`define MIE_OFF_TARGET 8'h08
`define MIE_OFF_STATUS 8'h0C
`define MIE_OFF_PC 8'h10
`define MIE_OFF_MEM 8'h14
`define MIE_OFF_WDT 8'h18
`define MIE_OP_LSB 0
`define MIE_OP_MSB 4
`define MIE_BIT_LSB 5
`define MIE_BIT_MSB 7
`define MIE_IMM_LSB 8
`define MIE_IMM_MSB 15
`define MIE_ST_Z 8
`define MIE_ST_C 9
`define MIE_ST_AC 10
`define MIE_ST_TO 11
`define MIE_ST_PDF 12
`define MIE_ST_GIE 13
`define MIE_ST_BUSY 14
`define MIE_ST_HALT 15
`define MIE_PC_DEPTH_LSB 16
`define MIE_PCW 13
`define MIE_STACK_LVLS 8
`define MIE_PCL_ADDR 8'h06
`define MIE_IRQ_VECTOR 13'h0004
`define MIE_PC_RESET 13'h0000
`define MIE_BYTE_ZERO 8'h00
`define MIE_BYTE_ONES 8'hFF
`define MIE_BCD_LIMIT 4'h9
`define MIE_BCD_LO 8'h06
`define MIE_BCD_HI 8'h60
`define MIE_CYC_TWO 2'h1
`define MIE_CYC_THREE 2'h2
`endif

// ===== common/mie_pkg.sv
// types of the instruction execute unit: operation codes, bus carrier, state
// assumes mie_regs.svh for widths
`include "mie_regs.svh"
package mie_pkg;
  typedef enum logic [4:0] {
    OP_IDLE, OP_INVOKE, OP_BRANCH, OP_EXIT, OP_EXIT_IMM, OP_IRQ_EXIT,
    OP_ZFILL, OP_ZFILL_BIT, OP_WDT_CLR, OP_POWER_DOWN, OP_INV, OP_INV_W,
    OP_BCD, OP_DEC, OP_DEC_W, OP_INC, OP_INC_W, OP_MOV_MA, OP_MOV_IA, OP_MOV_AM,
    OP_OR_M, OP_OR_I, OP_OR_INTO_M, OP_RL, OP_RL_W, OP_RLC, OP_RLC_W,
    OP_RR, OP_RR_W, OP_RRC, OP_RRC_W
  } mie_op_e;
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } mie_avl_req_s;
  typedef struct packed {
    logic [7:0] acc;
    logic z, c, ac, to, powerdown_flag, gie, halted;
    logic [`MIE_PCW-1:0] pc;
    logic [2:0] sp;
    logic [3:0] depth;
    logic [`MIE_STACK_LVLS-1:0][`MIE_PCW-1:0] stack;
    logic [1:0] busy_cnt;
    logic [7:0] addr;
    logic [`MIE_PCW-1:0] target;
    logic [7:0] wdt;
    logic [15:0] pre;
    logic ack;
    logic [31:0] rdata;
    logic sysclk_en;
  } mie_state_s;
endpackage

// ===== hdl/mie_execute.sv
// execute unit of an 8-bit core: accumulator, flags, program counter, return stack,
// watchdog and data memory, with operations launched over Avalon-MM
// assumes a same-clock master; i_irq_pending comes from logic on i_mclk
// Overview of operation
// (RQ1) invoke pushes pc+1, loads target, two cycles
// (RQ2) byte zero fill writes 00H, flags unchanged
// (RQ3) bit zero fill clears only the chosen bit, no flags
// (RQ4) watchdog clear resets counter, clears expired and powerdown flags
// (RQ5) invert gives ones-complement, sets zero flag; working form writes accumulator only
// (RQ6) bcd fix adds 6 per nibble above 9 or with half carry / carry
// (RQ7) bcd fix writes acc plus 00H/06H/60H/66H to memory; only carry changes
// (RQ8) decrement by one with zero flag; working form leaves memory alone
// (RQ9) power down halts, stops clock, clears watchdog and prescaler, sets powerdown; here it also clears the expired flag
// (RQ10) increment by one with zero flag; working form leaves memory alone
// (RQ11) branch loads target with a dummy cycle, two cycles, no flags
// (RQ12) copy moves memory/immediate to acc or acc to memory, no flags
// (RQ13) idle only advances the program counter
// (RQ14) or with memory or immediate sets zero flag; or-into-memory writes memory
// (RQ15) subroutine exit pops the stack into pc, no flags
// (RQ16) exit with immediate pops pc and loads immediate into acc
// (RQ17) interrupt exit pops pc, sets irq enable; pending irq taken first
// (RQ18) rotate left wraps bit 7 to bit 0, carry untouched
// (RQ19) rotate left through carry: old carry to bit 0, bit 7 to carry
// (RQ20) rotate right wraps bit 0 to bit 7, flags unchanged
// (RQ21) rotate right through carry: old carry to bit 7, bit 0 to carry
// (RQ22) a memory write landing on the pc low byte takes three cycles
// (RQ23) other operations take one cycle; unlisted flags keep their value; the exits here take two cycles, three when a pending irq is taken
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mie_regs.svh"
module mie_execute
  import mie_pkg::*;
#(
  parameter int MEM_DEPTH = 256,
  parameter logic [15:0] WDT_PRESCALE = 16'h0100
) (
  input wire logic i_mclk,                  // 125 MHz core clock
  input wire logic i_nrst,                  // async reset, active low
  input wire mie_avl_req_s i_avl,           // avalon request group
  input wire logic i_irq_pending,           // an interrupt source is waiting
  output logic o_waitrequest,               // avalon waitrequest
  output logic [31:0] o_readdata,           // avalon read data, registered
  output logic o_sysclk_en,                 // low while powered down, registered
  output logic [`MIE_PCW-1:0] o_pc          // program counter, registered
);
  mie_state_s s, n;
  logic rst_meta_r, rst_sync_r;
  logic [7:0] mem [MEM_DEPTH];
  logic mem_we;
  logic [7:0] mem_wdata, mem_waddr, m;
  logic busy, go, wr_fire, req;
  logic wm, wa, uz;
  logic [7:0] res, adj;
  logic [8:0] bsum;
  logic [2:0] bidx;
  logic [7:0] imm;
  logic [31:0] merged;
  mie_op_e op;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign busy = (s.busy_cnt != 2'h0);
  assign req = i_avl.read | i_avl.write;
  assign wr_fire = i_avl.write & s.ack;
  assign m = mem[s.addr];
  assign op = mie_op_e'(i_avl.writedata[`MIE_OP_MSB:`MIE_OP_LSB]);
  assign bidx = i_avl.writedata[`MIE_BIT_MSB:`MIE_BIT_LSB];
  assign imm = i_avl.writedata[`MIE_IMM_MSB:`MIE_IMM_LSB];
  assign go = wr_fire && (i_avl.address == `MIE_OFF_OPER) && !s.halted;
  // a request is held with waitrequest high for one cycle, a launch longer while an operation runs
  assign o_waitrequest = req & ~s.ack;
  assign o_readdata = s.rdata;
  assign o_sysclk_en = s.sysclk_en;
  assign o_pc = s.pc;

  always_comb begin
    n = s;
    mem_we = 1'b0;
    mem_wdata = `MIE_BYTE_ZERO;
    mem_waddr = s.addr;
    wm = 1'b0;
    wa = 1'b0;
    uz = 1'b0;
    res = `MIE_BYTE_ZERO;
    adj = `MIE_BYTE_ZERO;
    bsum = 9'h000;
    merged = 32'h00000000;
    // a launch waits until the previous operation has finished its cycles
    n.ack = req & ~s.ack & ~(i_avl.write & busy & (i_avl.address == `MIE_OFF_OPER));
    if (req & ~s.ack & i_avl.read) begin
      unique case (i_avl.address)
        `MIE_OFF_ADDR: n.rdata = {24'h000000, s.addr};
        `MIE_OFF_TARGET: n.rdata = {19'h00000, s.target};
        `MIE_OFF_STATUS: n.rdata = {16'h0000, s.halted, busy, s.gie, s.powerdown_flag, s.to, s.ac, s.c, s.z, s.acc};
        `MIE_OFF_PC: n.rdata = {12'h000, s.depth, 3'h0, s.pc};
        `MIE_OFF_MEM: n.rdata = {24'h000000, m};
        `MIE_OFF_WDT: n.rdata = {24'h000000, s.wdt};
        default: n.rdata = 32'h00000000;
      endcase
    end
    if (busy) begin
      n.busy_cnt = s.busy_cnt - 2'h1;
    end
    // watchdog runs off a prescaler enable and freezes with the stopped clock
    if (!s.halted) begin
      if (s.pre == WDT_PRESCALE - 16'h0001) begin
        n.pre = 16'h0000;
        if (s.wdt == `MIE_BYTE_ONES) begin
          n.to = 1'b1;
        end else begin
          n.wdt = s.wdt + 8'h01;
        end
      end else begin
        n.pre = s.pre + 16'h0001;
      end
    end
    if (wr_fire) begin
      unique case (i_avl.address)
        `MIE_OFF_ADDR: begin
          merged = be_merge({24'h000000, s.addr}, i_avl.writedata, i_avl.byteenable);
          n.addr = merged[7:0];
        end
        `MIE_OFF_TARGET: begin
          merged = be_merge({19'h00000, s.target}, i_avl.writedata, i_avl.byteenable);
          n.target = merged[`MIE_PCW-1:0];
        end
        `MIE_OFF_MEM: begin
          mem_we = i_avl.byteenable[0];
          mem_wdata = i_avl.writedata[7:0];
        end
        `MIE_OFF_STATUS: begin
          if (i_avl.byteenable[0]) begin
            n.acc = i_avl.writedata[7:0];
          end
          if (i_avl.byteenable[1]) begin
            n.z = i_avl.writedata[`MIE_ST_Z];
            n.c = i_avl.writedata[`MIE_ST_C];
            n.ac = i_avl.writedata[`MIE_ST_AC];
            n.gie = i_avl.writedata[`MIE_ST_GIE];
            // wake: writing the halt bit low restarts the clock
            if (!i_avl.writedata[`MIE_ST_HALT]) begin
              n.halted = 1'b0;
              n.sysclk_en = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
    if (go) begin
      n.pc = s.pc + 13'h0001; // RQ13 RQ23
      unique case (op)
        OP_INVOKE: begin
          n.stack[s.sp] = s.pc + 13'h0001; // RQ1
          n.sp = s.sp + 3'h1;
          n.depth = (s.depth == 4'h8) ? s.depth : s.depth + 4'h1;
          n.pc = s.target;
          n.busy_cnt = `MIE_CYC_TWO;
        end
        OP_BRANCH: begin
          n.pc = s.target; // RQ11
          n.busy_cnt = `MIE_CYC_TWO;
        end
        OP_EXIT, OP_EXIT_IMM, OP_IRQ_EXIT: begin
          n.pc = s.stack[s.sp - 3'h1]; // RQ15
          n.sp = s.sp - 3'h1;
          n.depth = (s.depth == 4'h0) ? s.depth : s.depth - 4'h1;
          n.busy_cnt = `MIE_CYC_TWO;
          if (op == OP_EXIT_IMM) begin
            n.acc = imm; // RQ16
          end
          if (op == OP_IRQ_EXIT) begin
            n.gie = 1'b1; // RQ17
            // the return address stays on the stack; pop and push cancel
            if (i_irq_pending) begin
              n.sp = s.sp;
              n.depth = s.depth;
              n.pc = `MIE_IRQ_VECTOR;
              n.gie = 1'b0;
              n.busy_cnt = `MIE_CYC_THREE;
            end
          end
        end
        OP_ZFILL: begin
          wm = 1'b1; // RQ2
          res = `MIE_BYTE_ZERO;
        end
        OP_ZFILL_BIT: begin
          wm = 1'b1;
          res = m & ~(8'h01 << bidx); // RQ3
        end
        OP_WDT_CLR: begin
          n.wdt = `MIE_BYTE_ZERO; // RQ4
          n.pre = 16'h0000;
          n.to = 1'b0;
          n.powerdown_flag = 1'b0;
        end
        OP_POWER_DOWN: begin
          n.halted = 1'b1; // RQ9
          n.sysclk_en = 1'b0;
          n.wdt = `MIE_BYTE_ZERO;
          n.pre = 16'h0000;
          n.powerdown_flag = 1'b1;
          n.to = 1'b0;
        end
        OP_INV, OP_INV_W: begin
          res = ~m; // RQ5
          uz = 1'b1;
          wm = (op == OP_INV);
          wa = (op == OP_INV_W);
        end
        OP_BCD: begin
          // both nibble tests look at the accumulator before any adjustment
          adj = (((s.acc[3:0] > `MIE_BCD_LIMIT) || s.ac) ? `MIE_BCD_LO : `MIE_BYTE_ZERO) // RQ6
            | (((s.acc[7:4] > `MIE_BCD_LIMIT) || s.c) ? `MIE_BCD_HI : `MIE_BYTE_ZERO);
          bsum = {1'b0, s.acc} + {1'b0, adj}; // RQ7
          res = bsum[7:0];
          wm = 1'b1;
          n.c = s.c | bsum[8];
        end
        OP_DEC, OP_DEC_W: begin
          res = m - 8'h01; // RQ8
          uz = 1'b1;
          wm = (op == OP_DEC);
          wa = (op == OP_DEC_W);
        end
        OP_INC, OP_INC_W: begin
          res = m + 8'h01; // RQ10
          uz = 1'b1;
          wm = (op == OP_INC);
          wa = (op == OP_INC_W);
        end
        OP_MOV_MA: begin
          res = m; // RQ12
          wa = 1'b1;
        end
        OP_MOV_IA: begin
          res = imm;
          wa = 1'b1;
        end
        OP_MOV_AM: begin
          res = s.acc;
          wm = 1'b1;
        end
        OP_OR_M, OP_OR_I, OP_OR_INTO_M: begin
          res = s.acc | ((op == OP_OR_I) ? imm : m); // RQ14
          uz = 1'b1;
          wm = (op == OP_OR_INTO_M);
          wa = (op != OP_OR_INTO_M);
        end
        OP_RL, OP_RL_W: begin
          res = {m[6:0], m[7]}; // RQ18
          wm = (op == OP_RL);
          wa = (op == OP_RL_W);
        end
        OP_RLC, OP_RLC_W: begin
          res = {m[6:0], s.c}; // RQ19
          n.c = m[7];
          wm = (op == OP_RLC);
          wa = (op == OP_RLC_W);
        end
        OP_RR, OP_RR_W: begin
          res = {m[0], m[7:1]}; // RQ20
          wm = (op == OP_RR);
          wa = (op == OP_RR_W);
        end
        OP_RRC, OP_RRC_W: begin
          res = {s.c, m[7:1]}; // RQ21
          n.c = m[0];
          wm = (op == OP_RRC);
          wa = (op == OP_RRC_W);
        end
        default: ;
      endcase
      if (wm) begin
        mem_we = 1'b1;
        mem_wdata = res;
        // the pc low byte lives in data memory: the write also redirects the pc
        if (s.addr == `MIE_PCL_ADDR) begin
          n.pc[7:0] = res; // RQ22
          n.busy_cnt = `MIE_CYC_THREE;
        end
      end
      if (wa) begin
        n.acc = res;
      end
      if (uz) begin
        n.z = (res == `MIE_BYTE_ZERO);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      s <= '0;
      s.pc <= `MIE_PC_RESET;
      s.sysclk_en <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // data memory keeps its contents through reset and power down
  always_ff @(posedge i_mclk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  sequence s_done_after_two;
    busy ##1 !busy;
  endsequence
  sequence s_done_after_three;
    busy [*2] ##1 !busy;
  endsequence

  chk_invoke_push: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RQ1
    go && op == OP_INVOKE |=> s.pc == $past(s.target) && s.stack[s.sp - 3'h1] == $past(s.pc) + 13'h0001
      ##0 s_done_after_two)
    else $error("invoke did not push pc+1 and jump in two cycles");
  chk_zfill_byte: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RQ2
    go && op == OP_ZFILL && s.addr != `MIE_PCL_ADDR |-> mem_we && mem_wdata == 8'h00 ##1 $stable({s.z, s.c, s.ac}))
    else $error("byte zero fill wrote wrong data or touched flags");
  chk_zfill_bit: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RQ3
    go && op == OP_ZFILL_BIT |-> mem_wdata == (m & ~(8'h01 << bidx)))
    else $error("bit zero fill changed other bits");
  chk_wdt_clear: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RQ4
    go && op == OP_WDT_CLR |=> s.wdt == 8'h00 && !s.to && !s.powerdown_flag)
    else $error("watchdog clear left state behind");
  chk_invert_zero: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RQ5
    go && op == OP_INV_W |-> !mem_we ##1 s.acc == ~$past(m) && s.z == ($past(m) == 8'hFF))
    else $error("invert to accumulator wrong");
  chk_bcd_flags: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RQ7
    go && op == OP_BCD |=> $stable({s.z, s.ac, s.acc}))
    else $error("bcd fix changed more than carry");
  chk_pd_halt: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RQ9
    go && op == OP_POWER_DOWN |=> s.halted && !o_sysclk_en && s.powerdown_flag && !s.to && s.wdt == 8'h00 ##1 $stable(s.pc))
    else $error("power down did not halt cleanly");
  chk_branch_two: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RQ11
    go && op == OP_BRANCH |=> s.pc == $past(s.target) ##0 s_done_after_two)
    else $error("branch not two cycles");
  chk_irq_exit: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RQ17
    go && op == OP_IRQ_EXIT && !i_irq_pending |=> s.gie && s.pc == $past(s.stack[s.sp - 3'h1]))
    else $error("interrupt exit did not restore pc and enable");
  chk_pcl_three: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RQ22
    go && wm && s.addr == `MIE_PCL_ADDR |=> s_done_after_three)
    else $error("pc low byte write not three cycles");
  chk_exit_pop: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RQ15
    go && op == OP_EXIT |=> s.pc == $past(s.stack[s.sp - 3'h1]) && $stable({s.z, s.c, s.ac}))
    else $error("subroutine exit did not pop the return address");
  chk_rlc_carry: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RQ19
    go && op == OP_RLC_W |-> !mem_we ##1 s.acc == {$past(m[6:0]), $past(s.c)} && s.c == $past(m[7]))
    else $error("rotate left through carry to accumulator wrong");
endmodule
`default_nettype wire

// ===== tb/mie_host_bfm.sv
// host-side partner: avalon master tasks and the interrupt source line
// assumes the slave answers by waitrequest on the same clock
`timescale 1ns/1ps
`default_nettype none
module mie_host_bfm
  import mie_pkg::*;
(
  input wire logic i_mclk,            // core clock
  input wire logic i_waitrequest,     // slave stall
  input wire logic [31:0] i_readdata, // slave read data
  output var mie_avl_req_s o_avl,     // request group
  output var logic o_irq_pending      // interrupt waiting
);
  logic held = 1'b0;
  initial begin
    o_avl = '0;
    o_irq_pending = 1'b0;
  end
  // keep leaves write up so a second launch follows with no idle cycle
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic keep,
                      output logic [31:0] q, output int w);
    logic ok;
    w = 0;
    ok = 1'b0;
    q = 32'h00000000;
    if (!held) @(posedge i_mclk);
    o_avl.read <= rd;
    o_avl.write <= ~rd;
    o_avl.address <= a;
    o_avl.byteenable <= 4'hF;
    o_avl.writedata <= d;
    while (!ok) begin
      // the request stands until the rising edge that sees waitrequest low; data is taken there only
      @(posedge i_mclk);
      ok = (i_waitrequest === 1'b0);
      if (ok) begin
        q = i_readdata;
      end else begin
        w++;
      end
    end
    held = keep;
    if (!keep) begin
      o_avl.read <= 1'b0;
      o_avl.write <= 1'b0;
    end
  endtask
  task automatic set_irq(input logic v);
    @(posedge i_mclk);
    o_irq_pending <= v;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench of the execute unit: data, flow, sleep and watchdog operations
// assumes mie_execute with a short watchdog prescale and the host model beside it
`timescale 1ns/1ps
`default_nettype none
`include "mie_regs.svh"
module tb_top
  import mie_pkg::*;
;
  localparam mie_op_e OPS [24] = '{OP_IDLE, OP_ZFILL, OP_ZFILL_BIT, OP_INV, OP_INV_W, OP_BCD, OP_DEC,
    OP_DEC_W, OP_INC, OP_INC_W, OP_MOV_MA, OP_MOV_IA, OP_MOV_AM, OP_OR_M, OP_OR_I, OP_OR_INTO_M, OP_RL,
    OP_RL_W, OP_RLC, OP_RLC_W, OP_RR, OP_RR_W, OP_RRC, OP_RRC_W};
  // memory, acc, immediate, bit index, then z, c, half carry
  localparam logic [31:0] VECS [4] = '{32'h00120004, 32'hFF000082, 32'h809A5AE1, 32'h01011001};
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  mie_avl_req_s avl;
  logic irq;
  logic waitreq;
  logic sysclk_en;
  logic [31:0] rdata;
  logic [31:0] q;
  logic [`MIE_PCW-1:0] pc;
  logic [`MIE_PCW-1:0] exp_pc = 13'h0000;
  int w;
  int failures = 0;
  int cmp_count = 0;
  always #4 mclk = ~mclk;
  mie_execute #(.MEM_DEPTH(256), .WDT_PRESCALE(16'h0004)) dut_u (.i_mclk(mclk), .i_nrst(nrst), .i_avl(avl),
    .i_irq_pending(irq), .o_waitrequest(waitreq), .o_readdata(rdata), .o_sysclk_en(sysclk_en), .o_pc(pc));
  mie_host_bfm host_u (.i_mclk(mclk), .i_waitrequest(waitreq), .i_readdata(rdata), .o_avl(avl),
    .o_irq_pending(irq));
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b0, a, d, 1'b0, q, w);
  endtask
  task automatic rd(input logic [7:0] a);
    host_u.xfer(1'b1, a, 32'h00000000, 1'b0, q, w);
  endtask
  task automatic op(input mie_op_e c, input logic [2:0] b, input logic [7:0] x);
    wr(`MIE_OFF_OPER, {16'h0000, x, b, c});
  endtask
  task automatic chk_pc(input logic [12:0] e);
    @(negedge mclk);
    chk("pc", {19'h00000, e}, {19'h00000, pc});
  endtask
  // the stall of an idle launch held right behind c shows how long c kept the unit busy
  task automatic timing(input mie_op_e c, input int k);
    logic [31:0] t;
    host_u.xfer(1'b0, `MIE_OFF_OPER, {27'h0000000, c}, 1'b1, t, w);
    host_u.xfer(1'b0, `MIE_OFF_OPER, 32'h00000000, 1'b0, t, w);
    chk("launch stall", 1 + k, w);
  endtask
  // expected {memory, acc, z, c} after one data operation
  function automatic logic [17:0] ref_op(mie_op_e o, logic [31:0] v);
    logic [7:0] m = v[31:24];
    logic [7:0] a = v[23:16];
    logic cy = v[1];
    logic z = v[2];
    logic [8:0] s = 9'h000;
    case (o)
      OP_ZFILL: m = 8'h00;
      OP_ZFILL_BIT: m[v[7:5]] = 1'b0;
      OP_INV: m = ~m;
      OP_INV_W: a = ~m;
      OP_DEC: m = m - 8'h01;
      OP_DEC_W: a = m - 8'h01;
      OP_INC: m = m + 8'h01;
      OP_INC_W: a = m + 8'h01;
      OP_MOV_MA: a = m;
      OP_MOV_IA: a = v[15:8];
      OP_MOV_AM: m = a;
      OP_OR_M: a = a | m;
      OP_OR_I: a = a | v[15:8];
      OP_OR_INTO_M: m = a | m;
      OP_RL: m = {m[6:0], m[7]};
      OP_RL_W: a = {m[6:0], m[7]};
      OP_RLC: {cy, m} = {m, cy};
      OP_RLC_W: {cy, a} = {m, cy};
      OP_RR: m = {m[0], m[7:1]};
      OP_RR_W: a = {m[0], m[7:1]};
      OP_RRC: {m, cy} = {cy, m};
      OP_RRC_W: {a, cy} = {cy, m};
      OP_BCD: begin
        s = {1'b0, a} + ((a[3:0] > 4'h9 || v[0]) ? 9'h006 : 9'h000)
          + ((a[7:4] > 4'h9 || cy) ? 9'h060 : 9'h000);
        m = s[7:0];
        cy = cy | s[8];
      end
      default: ;
    endcase
    if (o inside {OP_INV, OP_DEC, OP_INC, OP_OR_INTO_M}) z = (m == 8'h00);
    if (o inside {OP_INV_W, OP_DEC_W, OP_INC_W, OP_OR_M, OP_OR_I}) z = (a == 8'h00);
    return {m, a, z, cy};
  endfunction
  task automatic data_ops;
    logic [31:0] v;
    logic [17:0] e;
    for (int i = 0; i < 24; i++) begin
      for (int j = 0; j < 4; j++) begin
        v = VECS[j];
        wr(`MIE_OFF_ADDR, 32'h00000020 + 32'(j));
        wr(`MIE_OFF_MEM, {24'h000000, v[31:24]});
        wr(`MIE_OFF_STATUS, {21'h000000, v[0], v[1], v[2], v[23:16]});
        op(OPS[i], v[7:5], v[15:8]);
        exp_pc = exp_pc + 13'h0001;
        chk_pc(exp_pc);
        e = ref_op(OPS[i], v);
        rd(`MIE_OFF_MEM);
        chk("memory", {24'h000000, e[17:10]}, {24'h000000, q[7:0]});
        rd(`MIE_OFF_STATUS);
        chk("acc flags", {21'h000000, v[0], e[0], e[1], e[9:2]}, {21'h000000, q[10:0]});
      end
    end
  endtask
  task automatic flow_ops;
    logic [12:0] p;
    p = exp_pc;
    wr(`MIE_OFF_TARGET, 32'h00000123);
    timing(OP_INVOKE, 1);
    chk_pc(13'h0124);
    rd(`MIE_OFF_PC);
    chk("stack depth", 32'h00000001, {28'h0000000, q[19:16]});
    timing(OP_EXIT, 1);
    chk_pc(p + 13'h0002);
    op(OP_INVOKE, 3'h0, 8'h00);
    op(OP_EXIT_IMM, 3'h0, 8'h5C);
    chk_pc(p + 13'h0003);
    rd(`MIE_OFF_STATUS);
    chk("acc", 32'h0000005C, {24'h000000, q[7:0]});
    wr(`MIE_OFF_TARGET, 32'h00000456);
    timing(OP_BRANCH, 1);
    chk_pc(13'h0457);
    op(OP_INVOKE, 3'h0, 8'h00);
    timing(OP_IRQ_EXIT, 1);
    chk_pc(13'h0459);
    rd(`MIE_OFF_STATUS);
    chk("irq enable", 32'h00000001, {31'h00000000, q[13]});
    op(OP_INVOKE, 3'h0, 8'h00);
    host_u.set_irq(1'b1);
    timing(OP_IRQ_EXIT, 2);
    chk_pc(`MIE_IRQ_VECTOR + 13'h0001);
    host_u.set_irq(1'b0);
    op(OP_EXIT, 3'h0, 8'h00);
    chk_pc(13'h045A);
    wr(`MIE_OFF_ADDR, 32'h00000006);
    wr(`MIE_OFF_STATUS, 32'h00000040);
    timing(OP_MOV_AM, 2);
    chk_pc(13'h0441);
  endtask
  task automatic sleep_wdt;
    repeat (1100) @(posedge mclk);
    rd(`MIE_OFF_STATUS);
    chk("expired", 32'h00000001, {31'h00000000, q[11]});
    wr(`MIE_OFF_STATUS, 32'h00000011);
    op(OP_POWER_DOWN, 3'h0, 8'h00);
    @(negedge mclk);
    chk("sysclk en", 32'h00000000, {31'h00000000, sysclk_en});
    rd(`MIE_OFF_STATUS);
    chk("halt pdf to", 32'h00000006, {29'h00000000, q[15], q[12], q[11]});
    rd(`MIE_OFF_WDT);
    chk("wdt count", 32'h00000000, {24'h000000, q[7:0]});
    op(OP_MOV_IA, 3'h0, 8'h77);
    rd(`MIE_OFF_STATUS);
    chk("acc halted", 32'h00000011, {24'h000000, q[7:0]});
    wr(`MIE_OFF_STATUS, 32'h00000022);
    @(negedge mclk);
    chk("sysclk en", 32'h00000001, {31'h00000000, sysclk_en});
    op(OP_WDT_CLR, 3'h0, 8'h00);
    // read the counter first: the short prescale steps it again within a few cycles
    rd(`MIE_OFF_WDT);
    chk("wdt count", 32'h00000000, {24'h000000, q[7:0]});
    rd(`MIE_OFF_STATUS);
    chk("pdf to", 32'h00000000, {30'h00000000, q[12], q[11]});
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("pc reset", 32'h00000000, {19'h00000, pc});
    chk("sysclk reset", 32'h00000001, {31'h00000000, sysclk_en});
    timing(OP_IDLE, 0);
    exp_pc = 13'h0002;
    chk_pc(exp_pc);
    data_ops();
    flow_ops();
    sleep_wdt();
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    $display("CHECK FAILED run end expected done seen hang");
    print_verdict();
  end
endmodule
`default_nettype wire
